// *** design/sspw_slave.sv ***
module sspw_slave #(
  parameter sspw_pkg::sspw_res_e RES = sspw_pkg::SSPW_RES_50,
  parameter bit GRAY_CODE = 1'b1,
  parameter int FIFO_DEPTH = sspw_pkg::FIFO_DEPTH_DEF,
  parameter int MONO_CYC = sspw_pkg::MONO_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // position samples from the sensing front end
  input wire logic pos_valid,
  output logic pos_ready,
  input wire logic [sspw_pkg::FRAME_BITS_MAX-2:0] pos_value,
  // error sources
  input wire logic read_err,
  input wire logic freq_err,
  // serial link
  input wire logic ssi_clk,
  output logic ssi_data,
  output logic frame_busy
);
  localparam int PW = sspw_pkg::FRAME_BITS_MAX - 1;
  localparam int FLEN = sspw_pkg::sspw_frame_len(RES);
  localparam int CW = $clog2(MONO_CYC + 1);

  typedef enum logic [1:0] {SSPW_IDLE, SSPW_SHIFT, SSPW_MONO} sspw_st_e;

  logic [2:0] clk_sync_q;
  logic [1:0] err_sync_q;
  logic err_q;
  logic fall;
  logic rise;
  logic [PW-1:0] pos_q;
  logic [sspw_pkg::FRAME_BITS_MAX-1:0] sh_q;
  logic [4:0] left_q;
  logic [CW-1:0] mono_q;
  logic data_q;
  logic busy_q;
  sspw_st_e st_q;
  logic fifo_valid;
  logic [PW-1:0] fifo_data;

  function automatic logic [PW-1:0] to_gray(input logic [PW-1:0] b);
    return b ^ (b >> 1);
  endfunction

  sspw_fifo #(.WIDTH(PW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .in_valid(pos_valid),
    .in_ready(pos_ready),
    .in_data(pos_value),
    .out_valid(fifo_valid),
    .out_ready(1'b1),
    .out_data(fifo_data)
  );

  // latest position from the buffer, replaced by each entry as it is delivered
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pos_q <= sspw_pkg::POS_RESET[PW-1:0];
    end else if (fifo_valid) begin
      pos_q <= fifo_data;
    end
  end

  // pin synchronisers
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      clk_sync_q <= 3'h7;
      err_sync_q <= 2'h0;
      err_q <= 1'b0;
    end else begin
      clk_sync_q <= {clk_sync_q[1:0], ssi_clk};
      err_sync_q <= {err_sync_q[0], read_err | freq_err};
      err_q <= err_sync_q[1];
    end
  end

  assign fall = clk_sync_q[2] && !clk_sync_q[1];
  assign rise = !clk_sync_q[2] && clk_sync_q[1];

  // monoflop timer, restarted by every link clock edge of a frame
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      mono_q <= '0;
    end else if (st_q == SSPW_IDLE) begin
      if (fall) begin
        mono_q <= CW'(MONO_CYC);
      end
    end else if (fall || rise) begin
      mono_q <= CW'(MONO_CYC);
    end else if (mono_q != '0) begin
      mono_q <= mono_q - 1'b1;
    end
  end

  // busy from capture until the monoflop has run out
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= (st_q != SSPW_IDLE) || fall;
    end
  end

  // frame sequencer
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= SSPW_IDLE;
      sh_q <= '0;
      left_q <= 5'h00;
      data_q <= 1'b1;
    end else begin
      case (st_q)
        SSPW_IDLE: begin
          data_q <= 1'b1;
          if (fall) begin
            // position field then error flag, left aligned
            sh_q <= '0;
            sh_q[sspw_pkg::FRAME_BITS_MAX-1 -: PW] <= GRAY_CODE ? to_gray(pos_q) : pos_q;
            sh_q[sspw_pkg::FRAME_BITS_MAX-FLEN] <= !err_q;
            left_q <= 5'(FLEN);
            data_q <= 1'b0;
            st_q <= SSPW_SHIFT;
          end
        end
        SSPW_SHIFT, SSPW_MONO: begin
          if (rise) begin
            if (left_q != 5'h00) begin
              data_q <= sh_q[sspw_pkg::FRAME_BITS_MAX-1];
              sh_q <= {sh_q[sspw_pkg::FRAME_BITS_MAX-2:0], 1'b0};
              left_q <= left_q - 5'h01;
            end else begin
              data_q <= 1'b0;
              st_q <= SSPW_MONO;
            end
          end else if (!fall && mono_q == '0) begin
            st_q <= SSPW_IDLE;
            data_q <= 1'b1;
          end
        end
        default: begin
          st_q <= SSPW_IDLE;
        end
      endcase
    end
  end

  assign ssi_data = data_q;
  assign frame_busy = busy_q;

  a_idle_high: assert property (@(posedge ref_clk) disable iff (!resetn)
    (st_q == SSPW_IDLE && $past(st_q) == SSPW_IDLE) |-> data_q)
    else $error("data not high in idle");
  a_mono_restart: assert property (@(posedge ref_clk) disable iff (!resetn)
    (st_q != SSPW_IDLE && rise) |=> mono_q == CW'(MONO_CYC))
    else $error("monoflop not restarted");
  a_surplus_low: assert property (@(posedge ref_clk) disable iff (!resetn)
    (st_q != SSPW_IDLE && rise && left_q == 5'h00) |=> !data_q)
    else $error("surplus bit not low");
  a_capture_len: assert property (@(posedge ref_clk) disable iff (!resetn)
    (st_q == SSPW_IDLE && fall) |=> left_q == 5'(FLEN) && st_q == SSPW_SHIFT)
    else $error("wrong frame length");
  a_msb_first: assert property (@(posedge ref_clk) disable iff (!resetn)
    (st_q != SSPW_IDLE && rise && left_q != 5'h00) |=> data_q == $past(sh_q[sspw_pkg::FRAME_BITS_MAX-1]))
    else $error("wrong bit shifted");
  a_bit_count: assert property (@(posedge ref_clk) disable iff (!resetn)
    (st_q != SSPW_IDLE && rise && left_q != 5'h00) |=> left_q == $past(left_q) - 5'h01)
    else $error("bit count not decremented");
  a_no_recapture: assert property (@(posedge ref_clk) disable iff (!resetn)
    (st_q == SSPW_MONO && fall) |=> st_q != SSPW_SHIFT)
    else $error("capture during monoflop");
  a_err_flag: assert property (@(posedge ref_clk) disable iff (!resetn)
    (st_q == SSPW_IDLE && fall) |=> sh_q[sspw_pkg::FRAME_BITS_MAX-FLEN] == !$past(err_q))
    else $error("error flag wrong");
  a_mono_end: assert property (@(posedge ref_clk) disable iff (!resetn)
    (st_q == SSPW_MONO && mono_q == '0 && !rise && !fall) |=> st_q == SSPW_IDLE && data_q)
    else $error("monoflop end missed");
  a_capture_low: assert property (@(posedge ref_clk) disable iff (!resetn)
    (st_q == SSPW_IDLE && fall) |=> !data_q && busy_q)
    else $error("data not low after capture");
  a_word_frozen: assert property (@(posedge ref_clk) disable iff (!resetn)
    (st_q != SSPW_IDLE && !rise) |=> $stable(sh_q))
    else $error("captured word changed");
  a_busy_frame: assert property (@(posedge ref_clk) disable iff (!resetn)
    (st_q != SSPW_IDLE) |-> busy_q)
    else $error("busy low during frame");
  a_busy_idle: assert property (@(posedge ref_clk) disable iff (!resetn)
    (st_q == SSPW_IDLE && !fall) |=> !busy_q)
    else $error("busy high in idle");
  a_mono_count: assert property (@(posedge ref_clk) disable iff (!resetn)
    (st_q != SSPW_IDLE && !rise && !fall && mono_q != '0) |=> mono_q == $past(mono_q) - 1'b1)
    else $error("monoflop not counting");
  a_pos_follow: assert property (@(posedge ref_clk) disable iff (!resetn)
    fifo_valid |=> pos_q == $past(fifo_data))
    else $error("position not taken");

  c_frame: cover property (@(posedge ref_clk) disable iff (!resetn) st_q == SSPW_IDLE && fall);
  c_surplus: cover property (@(posedge ref_clk) disable iff (!resetn) st_q == SSPW_MONO && rise);
  c_timeout: cover property (@(posedge ref_clk) disable iff (!resetn) st_q == SSPW_MONO ##1 st_q == SSPW_IDLE);
  c_error: cover property (@(posedge ref_clk) disable iff (!resetn) st_q == SSPW_IDLE && fall && err_q);
  c_refresh: cover property (@(posedge ref_clk) disable iff (!resetn) st_q == SSPW_SHIFT && fall);
endmodule

// *** inc/sspw_pkg.sv ***
package sspw_pkg;
  // frame and timing constants
  localparam int FRAME_BITS_MAX = 24;
  localparam int FRAME_BITS_DEF = 19;
  localparam int ERR_BIT_POS = 1;
  localparam int REF_CLK_MHZ = 200;
  localparam int MONO_TIME_NS = 12000;
  localparam int MONO_CYCLES = (MONO_TIME_NS * REF_CLK_MHZ) / 1000;
  localparam int FIFO_DEPTH_DEF = 32;
  localparam logic [23:0] POS_RESET = 24'h000000;
  // frame length per resolution variant
  typedef enum logic [2:0] {SSPW_RES_50, SSPW_RES_10, SSPW_RES_5, SSPW_RES_2, SSPW_RES_1} sspw_res_e;
  function automatic int sspw_frame_len(input sspw_res_e r);
    case (r)
      SSPW_RES_50: return 19;
      SSPW_RES_10: return 21;
      SSPW_RES_5: return 22;
      SSPW_RES_2: return 23;
      default: return 24;
    endcase
  endfunction
endpackage

// *** design/sspw_fifo.sv ***
module sspw_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;
  logic ready_q;
  logic [AW:0] cnt_d;

  assign in_ready = ready_q;
  assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      ready_q <= 1'b1;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_d;
      ready_q <= (cnt_d != (AW+1)'(DEPTH));
    end
  end
endmodule

// *** bench/sspw_master_model.sv ***
module sspw_master_model (
  // system clock
  input wire logic ref_clk,
  // serial link
  output logic ssi_clk,
  input wire logic ssi_data
);
  timeunit 1ns;
  timeprecision 100ps;
  // clock rests high between bursts
  initial ssi_clk = 1'b1;
  // link rate raised above the real range to keep runs short
  task automatic half();
    repeat (16) @(posedge ref_clk);
  endtask
  // one burst of n rising edges; bits gathered msb first, sampled late in the high phase
  task automatic read(input int n, output logic [31:0] w);
    w = 32'h0;
    @(posedge ref_clk) ssi_clk <= 1'b0;
    half();
    for (int i = 0; i < n; i++) begin
      ssi_clk <= 1'b1;
      half();
      w = {w[30:0], ssi_data};
      // stop right after the last rising edge, no padding
      if (i < n - 1) begin
        ssi_clk <= 1'b0;
        half();
      end
    end
  endtask
endmodule

// *** bench/sspw_slave_bench.sv ***
module sspw_slave_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int MONO = 40;
  logic ref_clk, resetn, pos_valid, pos_ready, read_err, freq_err, ssi_clk, ssi_data, frame_busy;
  logic ssi_clk_b, ssi_data_b, busy_b, ready_b;
  logic [22:0] pos_value;
  logic [31:0] w;
  int mismatches = 0;
  int n_checks = 0;
  int cyc = 0;
  sspw_slave #(.MONO_CYC(MONO)) uut (
    .ref_clk(ref_clk), .resetn(resetn), .pos_valid(pos_valid), .pos_ready(pos_ready),
    .pos_value(pos_value), .read_err(read_err), .freq_err(freq_err), .ssi_clk(ssi_clk),
    .ssi_data(ssi_data), .frame_busy(frame_busy));
  sspw_master_model m (.ref_clk(ref_clk), .ssi_clk(ssi_clk), .ssi_data(ssi_data));
  sspw_slave #(.RES(sspw_pkg::SSPW_RES_1), .GRAY_CODE(1'b0), .MONO_CYC(MONO)) uut_bin (
    .ref_clk(ref_clk), .resetn(resetn), .pos_valid(pos_valid), .pos_ready(ready_b),
    .pos_value(pos_value), .read_err(read_err), .freq_err(freq_err), .ssi_clk(ssi_clk_b),
    .ssi_data(ssi_data_b), .frame_busy(busy_b));
  sspw_master_model m_bin (.ref_clk(ref_clk), .ssi_clk(ssi_clk_b), .ssi_data(ssi_data_b));
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      results();
    end
  end
  // gray code of the 18-bit position held in the top of the field
  function automatic logic [17:0] gray(input logic [22:0] v);
    gray = v[22:5] ^ (v[22:5] >> 1);
  endfunction
  task automatic push(input logic [22:0] v);
    @(posedge ref_clk) begin
      pos_valid <= 1'b1;
      pos_value <= v;
    end
    @(posedge ref_clk) pos_valid <= 1'b0;
    chk({pos_ready, ready_b}, 2'h3);
    repeat (8) @(posedge ref_clk);
  endtask
  // pause beyond the monoflop before the next burst
  task automatic quiet();
    repeat (MONO + 24) @(posedge ref_clk);
  endtask
  // new sample arrives mid-frame, frame must keep the captured one
  task automatic t_frame();
    push(23'h2d2d2d);
    fork
      m.read(19, w);
      begin
        repeat (40) @(posedge ref_clk);
        pos_valid <= 1'b1;
        pos_value <= 23'h7fffff;
        @(posedge ref_clk) pos_valid <= 1'b0;
      end
    join
    chk(w[18:0], {gray(23'h2d2d2d), 1'b1});
    repeat (MONO - 24) @(posedge ref_clk);
    chk(frame_busy, 1'b1);
    repeat (40) @(posedge ref_clk);
    chk(ssi_data, 1'b1);
    chk(frame_busy, 1'b0);
  endtask
  task automatic t_surplus();
    push(23'h0abcde);
    m.read(24, w);
    chk(w[23:0], {gray(23'h0abcde), 1'b1, 5'h00});
    quiet();
  endtask
  // reading error, then frequency error
  task automatic t_err();
    for (int i = 0; i < 2; i++) begin
      @(posedge ref_clk) begin
        read_err <= (i == 0);
        freq_err <= (i == 1);
      end
      repeat (8) @(posedge ref_clk);
      m.read(19, w);
      chk(w[0], 1'b0);
      read_err <= 1'b0;
      freq_err <= 1'b0;
      quiet();
    end
  endtask
  // binary code, longest frame, one surplus clock
  task automatic t_binary();
    push(23'h5a5a5a);
    m_bin.read(25, w);
    chk(w[24:0], {23'h5a5a5a, 1'b1, 1'b0});
    chk(busy_b, 1'b1);
    quiet();
    chk(busy_b, 1'b0);
    chk(ssi_data_b, 1'b1);
  endtask
  initial begin
    resetn = 1'b0;
    pos_valid = 1'b0;
    pos_value = 23'h0;
    read_err = 1'b0;
    freq_err = 1'b0;
    repeat (16) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk(ssi_data, 1'b1);
    t_frame();
    quiet();
    t_surplus();
    t_err();
    t_binary();
    results();
  end
endmodule
